// File: dmsd_pkg.sv
// shared constants, operation codes and types for the multiplier/scaler datapath
`default_nettype none
package dmsd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DMSD_WORD_W  = 16;
  localparam int DMSD_ACC_W   = 32;
  localparam int DMSD_IMM_W   = 13;
  localparam int DMSD_SHIFT_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // scaling and product shift figures
  localparam logic [4:0] DMSD_MAX_SCALE     = 5'h10;
  localparam int         DMSD_PSHIFT_LEFT1  = 1;
  localparam int         DMSD_PSHIFT_LEFT4  = 4;
  localparam int         DMSD_PSHIFT_RIGHT6 = 6;

  ////////////////////////////////////////////////////////////////////////////
  // product shift select encodings
  localparam logic [1:0] DMSD_PM_NONE   = 2'h0;
  localparam logic [1:0] DMSD_PM_LEFT1  = 2'h1;
  localparam logic [1:0] DMSD_PM_LEFT4  = 2'h2;
  localparam logic [1:0] DMSD_PM_RIGHT6 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // saturation limits
  localparam logic [31:0] DMSD_SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] DMSD_SAT_NEG = 32'h8000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside the two status words
  localparam int DMSD_ST0_OVM_POS = 11;
  localparam int DMSD_ST1_TC_POS  = 11;
  localparam int DMSD_ST1_SXM_POS = 10;
  localparam int DMSD_ST1_XF_POS  = 4;
  localparam int DMSD_ST1_PM_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic       DMSD_OVM_RST = 1'b0;
  localparam logic [1:0] DMSD_PM_RST  = 2'h0;
  localparam logic       DMSD_SXM_RST = 1'b1;
  localparam logic       DMSD_TC_RST  = 1'b0;
  localparam logic       DMSD_XF_RST  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // operations issued by instruction decode
  typedef enum logic [4:0] {
    DMSD_OP_NOP        = 5'h00,
    DMSD_OP_LOAD_OPND  = 5'h01,
    DMSD_OP_LOAD_PROD  = 5'h02,
    DMSD_OP_LOAD_ADD   = 5'h03,
    DMSD_OP_LOAD_SUB   = 5'h04,
    DMSD_OP_LOAD_MOVE  = 5'h05,
    DMSD_OP_MPY        = 5'h06,
    DMSD_OP_MPY_IMM    = 5'h07,
    DMSD_OP_UNSIGNED_MULTIPLY_OP       = 5'h08,
    DMSD_OP_MAC        = 5'h09,
    DMSD_OP_MAC_MOVE   = 5'h0A,
    DMSD_OP_SQR_ADD    = 5'h0B,
    DMSD_OP_SQR_SUB    = 5'h0C,
    DMSD_OP_STORE_HI   = 5'h0D,
    DMSD_OP_STORE_LO   = 5'h0E,
    DMSD_OP_LOAD_PHI   = 5'h0F,
    DMSD_OP_SET_PM     = 5'h10,
    DMSD_OP_LOAD_ST0   = 5'h11,
    DMSD_OP_LOAD_ST1   = 5'h12,
    DMSD_OP_SET_BIT    = 5'h13,
    DMSD_OP_CLR_BIT    = 5'h14,
    DMSD_OP_BIT_TEST   = 5'h15,
    DMSD_OP_BIT_DYN    = 5'h16,
    DMSD_OP_AUX_CMP    = 5'h17,
    DMSD_OP_NORMALISE_OP       = 5'h18,
    DMSD_OP_ADD_SHIFT  = 5'h19,
    DMSD_OP_SUB_SHIFT  = 5'h1A,
    DMSD_OP_LOAD_SHIFT = 5'h1B,
    DMSD_OP_ADD_DYN    = 5'h1C,
    DMSD_OP_ADD_NOSX   = 5'h1D
  } dmsd_op_t;

  // control bit chosen by set/clear operations
  typedef enum logic [1:0] {
    DMSD_CTL_OVM = 2'h0,
    DMSD_CTL_SXM = 2'h1,
    DMSD_CTL_TC  = 2'h2,
    DMSD_CTL_XF  = 2'h3
  } dmsd_ctl_t;

  // multiplier sequencing, one-hot
  typedef enum logic [1:0] {
    DMSD_MUL_IDLE = 2'b01,
    DMSD_MUL_IMM  = 2'b10
  } dmsd_mul_state_t;

endpackage : dmsd_pkg
`default_nettype wire

// File: dmsd_shift_if.sv
// interface between the datapath core and its two shifters
`timescale 1ns/1ps
`default_nettype none
interface dmsd_shift_if;
  logic [15:0] data_word;
  logic [4:0]  shift_count;
  logic        sign_extend;
  logic [31:0] scaled_word;
  logic [31:0] product;
  logic [1:0]  product_mode;
  logic [31:0] shifted_product;

  modport shifter (
    input  data_word, shift_count, sign_extend, product, product_mode,
    output scaled_word, shifted_product
  );
  modport core (
    output data_word, shift_count, sign_extend, product, product_mode,
    input  scaled_word, shifted_product
  );
endinterface : dmsd_shift_if
`default_nettype wire

// File: dmsd_shifters.sv
// combinational input scaling shifter and product shifter
`timescale 1ns/1ps
`default_nettype none
module dmsd_shifters
  import dmsd_pkg::*;
(
  // link to the datapath core
  dmsd_shift_if.shifter sh
);

  ////////////////////////////////////////////////////////////////////////////
  // input scaling shifter
  wire        fill_bit;
  wire [31:0] widened;
  wire [4:0]  count;

  assign fill_bit = sh.sign_extend & sh.data_word[15];
  assign widened  = {{16{fill_bit}}, sh.data_word};
  // counts above sixteen are clipped rather than wrapped
  assign count    = (sh.shift_count > DMSD_MAX_SCALE) ? DMSD_MAX_SCALE : sh.shift_count;
  assign sh.scaled_word = widened << count;

  ////////////////////////////////////////////////////////////////////////////
  // product shifter, only on the path out of the product register
  wire [31:0] prod_left1;
  wire [31:0] prod_left4;
  wire [31:0] prod_right6;

  assign prod_left1  = sh.product << DMSD_PSHIFT_LEFT1;
  assign prod_left4  = sh.product << DMSD_PSHIFT_LEFT4;
  assign prod_right6 = 32'($signed(sh.product) >>> DMSD_PSHIFT_RIGHT6);

  assign sh.shifted_product =
    (sh.product_mode == DMSD_PM_LEFT1)  ? prod_left1  :
    (sh.product_mode == DMSD_PM_LEFT4)  ? prod_left4  :
    (sh.product_mode == DMSD_PM_RIGHT6) ? prod_right6 :
                                          sh.product;

endmodule : dmsd_shifters
`default_nettype wire

// File: dmsd_datapath.sv
// multiplier, product register, accumulator update and status mode bits
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - saturate mode 0 lets overflow wrap; 1 clamps accumulator to extreme value
// - product shift select 00 passes the product unshifted
// - select 01 shifts product left one, zero into the lsb
// - select 10 shifts product left four, zeros into low bits
// - select 11 shifts product right six with sign extension
// - shift acts only on the way out; stored product unchanged
// - reset clears product shift select; set-mode and status load write it
// - sign extend mode 1 extends scaled data, 0 suppresses; reset sets it
// - add without sign extension never extends its operand
// - general output flag drives the pin; set/clear update; reset sets it
// - scaling shifter maps 16 bits to 32 bits with no extra cycle
// - scaling shifts left 0 to 16, zero low fill, high per sign mode
// - shift count from instruction constant or operand register
// - 16x16 product in one cycle, signed except the unsigned multiply
// - multiply by 13-bit immediate yields a product every two cycles
// - operand load runs alongside load/add/subtract/move on previous product
// - multiply-accumulate takes program and data operands; coefficient address steps
// - move variants pulse the sample move strobe on every issue, repeating or not
// - square operations feed the same value to both multiplier inputs
// - product stores and alu moves go through shifter; multiply by zero clears
// - saturation values are 7FFFFFFF positive and 80000000 negative
module dmsd_datapath
  import dmsd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // operation issue from instruction decode
  input  wire logic        op_valid,
  input  wire dmsd_op_t    op,
  input  wire dmsd_ctl_t   control_sel,
  // operands from the buses and the instruction word
  input  wire logic [15:0] data_word,
  input  wire logic [15:0] prog_word,
  input  wire logic [12:0] imm_word,
  input  wire logic [4:0]  shift_const,
  input  wire logic [3:0]  bit_index,
  input  wire logic [1:0]  pm_field,
  input  wire logic [15:0] status_zero_in,
  input  wire logic [15:0] status_one_in,
  // sequencing context
  input  wire logic        aux_compare_true,
  input  wire logic        repeat_active,
  input  wire logic [15:0] coef_start_addr,
  // datapath state
  output logic      [31:0] accumulator,
  output logic      [31:0] product_register,
  output logic      [15:0] multiplier_operand_register,
  output logic             overflow_event,
  // mode and flag bits
  output logic             overflow_saturate_mode,
  output logic      [1:0]  product_shift_select,
  output logic             sign_extend_mode,
  output logic             test_flag,
  output logic             general_output_flag_pin,
  // memory side strobes and immediate multiply busy flag
  output logic      [15:0] store_word,
  output logic             store_valid,
  output logic             data_move_strobe,
  output logic      [15:0] coef_addr,
  output logic             mult_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // shifters
  dmsd_shift_if sh ();

  dmsd_shifters dmsd_shifters_inst (
    .sh (sh.shifter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // issue and decode
  dmsd_mul_state_t mul_state;
  dmsd_mul_state_t next_mul_state;
  logic [15:0]     imm_hold;

  wire take;
  wire is_mac;
  wire is_sqr;
  wire is_mpy;
  wire loads_operand;
  wire uses_multiplier_operand_register_shift;
  wire uses_product;
  wire alu_sub;
  wire alu_load;
  wire acc_write;

  // the core must not issue while the immediate multiply finishes
  assign take = op_valid & (mul_state == DMSD_MUL_IDLE);

  assign is_mac = (op == DMSD_OP_MAC) | (op == DMSD_OP_MAC_MOVE);
  assign is_sqr = (op == DMSD_OP_SQR_ADD) | (op == DMSD_OP_SQR_SUB);
  assign is_mpy = (op == DMSD_OP_MPY) | (op == DMSD_OP_UNSIGNED_MULTIPLY_OP) | is_mac | is_sqr;

  // operand loads; all but the plain operand load overlap an alu step on the previous product
  assign loads_operand = (op == DMSD_OP_LOAD_OPND) | (op == DMSD_OP_LOAD_PROD)
                       | (op == DMSD_OP_LOAD_ADD) | (op == DMSD_OP_LOAD_SUB)
                       | (op == DMSD_OP_LOAD_MOVE) | is_mac | is_sqr;

  assign uses_multiplier_operand_register_shift = (op == DMSD_OP_ADD_DYN);
  assign uses_product = (op == DMSD_OP_LOAD_PROD) | (op == DMSD_OP_LOAD_ADD)
                      | (op == DMSD_OP_LOAD_SUB) | (op == DMSD_OP_LOAD_MOVE)
                      | is_mac | is_sqr;
  assign alu_sub  = (op == DMSD_OP_LOAD_SUB) | (op == DMSD_OP_SQR_SUB)
                  | (op == DMSD_OP_SUB_SHIFT);
  assign alu_load = (op == DMSD_OP_LOAD_PROD) | (op == DMSD_OP_LOAD_SHIFT);
  assign acc_write = take & (uses_product | alu_load | (op == DMSD_OP_ADD_SHIFT)
                   | (op == DMSD_OP_SUB_SHIFT) | (op == DMSD_OP_ADD_DYN)
                   | (op == DMSD_OP_ADD_NOSX));

  ////////////////////////////////////////////////////////////////////////////
  // shifter inputs
  assign sh.data_word    = data_word;
  assign sh.shift_count  = uses_multiplier_operand_register_shift ? {1'b0, multiplier_operand_register[3:0]}
                                           : shift_const;
  // the add without extension ignores the mode bit entirely
  assign sh.sign_extend  = sign_extend_mode & (op != DMSD_OP_ADD_NOSX);
  assign sh.product      = product_register;
  assign sh.product_mode = product_shift_select;

  ////////////////////////////////////////////////////////////////////////////
  // multiplier
  wire [15:0] mul_a;
  wire [15:0] mul_b;
  wire [31:0] prod_signed;
  wire [31:0] prod_unsigned;
  wire [31:0] prod_new;
  wire [15:0] imm_ext;

  assign imm_ext = {{3{imm_word[12]}}, imm_word};
  // squaring routes the data word to both inputs
  assign mul_a = (is_sqr && mul_state == DMSD_MUL_IDLE) ? data_word
                 : multiplier_operand_register;
  assign mul_b = (mul_state == DMSD_MUL_IMM) ? imm_hold :
                 is_mac                      ? prog_word :
                                               data_word;

  assign prod_signed   = 32'($signed(mul_a) * $signed(mul_b));
  assign prod_unsigned = 32'(mul_a * mul_b);
  assign prod_new = ((op == DMSD_OP_UNSIGNED_MULTIPLY_OP) && (mul_state == DMSD_MUL_IDLE))
                  ? prod_unsigned : prod_signed;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator path with saturation
  wire [31:0] alu_b;
  wire [32:0] acc_wide;
  wire [32:0] b_wide;
  wire [32:0] sum_wide;
  wire        sum_ovf;
  wire [31:0] sat_value;
  wire [31:0] next_acc;

  assign alu_b    = uses_product ? sh.shifted_product : sh.scaled_word;
  assign acc_wide = {accumulator[31], accumulator};
  assign b_wide   = {alu_b[31], alu_b};
  assign sum_wide = alu_sub ? (acc_wide - b_wide) : (acc_wide + b_wide);
  assign sum_ovf  = sum_wide[32] ^ sum_wide[31];

  // the extra sign bit tells which way the result ran off
  assign sat_value = !(overflow_saturate_mode && sum_ovf) ? sum_wide[31:0] :
                     sum_wide[32] ? DMSD_SAT_NEG : DMSD_SAT_POS;
  assign next_acc  = alu_load ? alu_b : sat_value;

  ////////////////////////////////////////////////////////////////////////////
  // immediate multiply sequencing
  always_comb begin
    case (mul_state)
      DMSD_MUL_IDLE: begin
        next_mul_state = (take && op == DMSD_OP_MPY_IMM) ? DMSD_MUL_IMM : DMSD_MUL_IDLE;
      end
      DMSD_MUL_IMM: begin
        next_mul_state = DMSD_MUL_IDLE;
      end
      default: begin
        next_mul_state = DMSD_MUL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mul_state <= DMSD_MUL_IDLE;
      imm_hold  <= 16'h0000;
      mult_busy <= 1'b0;
    end else begin
      mul_state <= next_mul_state;
      mult_busy <= (next_mul_state == DMSD_MUL_IMM);
      if (take && op == DMSD_OP_MPY_IMM) begin
        imm_hold <= imm_ext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product and operand registers
  wire [31:0] next_product;
  wire [15:0] next_operand;

  // an immediate zero gives an all-zero product, which is how software clears it
  assign next_product =
    (mul_state == DMSD_MUL_IMM)      ? prod_signed :
    (take && is_mpy)                 ? prod_new :
    (take && op == DMSD_OP_LOAD_PHI) ? {data_word, product_register[15:0]} :
                                       product_register;
  assign next_operand = (take && loads_operand) ? data_word
                                                : multiplier_operand_register;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      product_register            <= 32'h0000_0000;
      multiplier_operand_register <= 16'h0000;
    end else begin
      product_register            <= next_product;
      multiplier_operand_register <= next_operand;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accumulator    <= 32'h0000_0000;
      overflow_event <= 1'b0;
    end else begin
      overflow_event <= acc_write & ~alu_load & sum_ovf;
      if (acc_write) begin
        accumulator <= next_acc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode and flag bits
  wire set_op;
  wire clr_op;
  wire ctl_write;
  wire bit_dyn_hit;
  wire bit_fix_hit;
  wire next_ovm;
  wire next_sxm;
  wire next_xf;
  wire next_tc;
  wire [1:0] next_pm;

  assign set_op    = take & (op == DMSD_OP_SET_BIT);
  assign clr_op    = take & (op == DMSD_OP_CLR_BIT);
  assign ctl_write = set_op | clr_op;

  assign bit_dyn_hit = data_word[4'hF - multiplier_operand_register[3:0]];
  assign bit_fix_hit = data_word[4'hF - bit_index];

  assign next_ovm =
    (ctl_write && control_sel == DMSD_CTL_OVM) ? set_op :
    (take && op == DMSD_OP_LOAD_ST0) ? status_zero_in[DMSD_ST0_OVM_POS] :
                                       overflow_saturate_mode;
  assign next_sxm =
    (ctl_write && control_sel == DMSD_CTL_SXM) ? set_op :
    (take && op == DMSD_OP_LOAD_ST1) ? status_one_in[DMSD_ST1_SXM_POS] :
                                       sign_extend_mode;
  assign next_xf =
    (ctl_write && control_sel == DMSD_CTL_XF) ? set_op
                                              : general_output_flag_pin;
  assign next_pm =
    (take && op == DMSD_OP_SET_PM)   ? pm_field :
    (take && op == DMSD_OP_LOAD_ST1) ? status_one_in[DMSD_ST1_PM_LSB +: 2] :
                                       product_shift_select;
  assign next_tc =
    !take                                  ? test_flag :
    (op == DMSD_OP_BIT_DYN)                ? bit_dyn_hit :
    (op == DMSD_OP_BIT_TEST)               ? bit_fix_hit :
    (op == DMSD_OP_AUX_CMP)                ? aux_compare_true :
    (op == DMSD_OP_NORMALISE_OP)                   ? (accumulator[31] ^ accumulator[30]) :
    (op == DMSD_OP_LOAD_ST1)               ? status_one_in[DMSD_ST1_TC_POS] :
    (ctl_write && control_sel == DMSD_CTL_TC) ? set_op :
                                             test_flag;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      overflow_saturate_mode  <= DMSD_OVM_RST;
      product_shift_select    <= DMSD_PM_RST;
      sign_extend_mode        <= DMSD_SXM_RST;
      test_flag               <= DMSD_TC_RST;
      general_output_flag_pin <= DMSD_XF_RST;
    end else begin
      overflow_saturate_mode  <= next_ovm;
      product_shift_select    <= next_pm;
      sign_extend_mode        <= next_sxm;
      test_flag               <= next_tc;
      general_output_flag_pin <= next_xf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product stores, sample moves and coefficient stepping
  wire store_op;
  wire move_op;
  wire mac_take;

  assign store_op = take & ((op == DMSD_OP_STORE_HI) | (op == DMSD_OP_STORE_LO));
  // the core only pulses the move strobe; the memory side copies the sample one location up
  assign move_op  = take & ((op == DMSD_OP_LOAD_MOVE) | (op == DMSD_OP_MAC_MOVE));
  assign mac_take = take & is_mac;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      store_word       <= 16'h0000;
      store_valid      <= 1'b0;
      data_move_strobe <= 1'b0;
      coef_addr        <= 16'h0000;
    end else begin
      store_valid      <= store_op;
      data_move_strobe <= move_op;
      if (store_op) begin
        // saved halves carry the shift, so restore needs shift select at zero
        store_word <= (op == DMSD_OP_STORE_HI) ? sh.shifted_product[31:16]
                                               : sh.shifted_product[15:0];
      end
      if (mac_take) begin
        coef_addr <= repeat_active ? 16'(coef_addr + 16'h0001)
                                   : coef_start_addr;
      end
    end
  end

endmodule : dmsd_datapath
`default_nettype wire

// File: dmsd_chk_sva.sv
// port assertions for the multiplier/scaler datapath
`timescale 1ns/1ps
`default_nettype none
module dmsd_chk
  import dmsd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // operation issue
  input wire logic        op_valid,
  input wire dmsd_op_t    op,
  input wire dmsd_ctl_t   control_sel,
  input wire logic [15:0] data_word,
  input wire logic [12:0] imm_word,
  input wire logic [1:0]  pm_field,
  // datapath state
  input wire logic [31:0] product_register,
  input wire logic [15:0] multiplier_operand_register,
  input wire logic [1:0]  product_shift_select,
  input wire logic        sign_extend_mode,
  input wire logic        general_output_flag_pin,
  input wire logic        mult_busy
);
  default clocking cb @(posedge clk); endclocking
  wire               take = op_valid && !mult_busy;
  // widened before multiplying so the square keeps its full 32 bits
  wire signed [31:0] sq   = $signed(data_word) * $signed(data_word);
  ////////////////////////////////////////////////////////////////////////////
  a_pm_reset_clear: assert property (!rst_b |=> product_shift_select == 2'h0)
    else $error("product shift select not cleared by reset");
  a_sxm_reset_set: assert property (!rst_b |=> sign_extend_mode)
    else $error("sign extend mode not set by reset");
  a_pin_reset_set: assert property (!rst_b |=> general_output_flag_pin)
    else $error("output flag pin not set by reset");
  a_pm_load_field: assert property (disable iff (!rst_b)
    take && op == DMSD_OP_SET_PM |=> product_shift_select == $past(pm_field))
    else $error("product shift select not loaded");
  a_pin_set_clear: assert property (disable iff (!rst_b)
    take && control_sel == DMSD_CTL_XF && op inside {DMSD_OP_SET_BIT, DMSD_OP_CLR_BIT}
    |=> general_output_flag_pin == ($past(op) == DMSD_OP_SET_BIT))
    else $error("output flag pin not updated");
  a_imm_two_cycle: assert property (disable iff (!rst_b)
    take && op == DMSD_OP_MPY_IMM |=> mult_busy ##1 !mult_busy)
    else $error("immediate multiply not two cycles");
  a_busy_hold_opnd: assert property (disable iff (!rst_b)
    mult_busy |=> $stable(multiplier_operand_register))
    else $error("operand register changed while busy");
  a_zero_clears: assert property (disable iff (!rst_b)
    take && op == DMSD_OP_MPY_IMM && imm_word == 13'h0000
    |-> ##2 product_register == 32'h0000_0000)
    else $error("multiply by zero did not clear product");
  a_square_same: assert property (disable iff (!rst_b)
    take && op == DMSD_OP_SQR_ADD |=> $signed(product_register) == $past(sq))
    else $error("square did not use one value twice");
  c_mac_move: cover property (take && op == DMSD_OP_MAC_MOVE);
  c_mpy_imm: cover property (take && op == DMSD_OP_MPY_IMM);
  c_pm_right: cover property (take && op == DMSD_OP_SET_PM
    ##1 product_shift_select == DMSD_PM_RIGHT6);
endmodule : dmsd_chk
bind dmsd_datapath dmsd_chk dmsd_chk_inst (.clk, .rst_b, .op_valid, .op, .control_sel,
  .data_word, .imm_word, .pm_field, .product_register, .multiplier_operand_register,
  .product_shift_select, .sign_extend_mode, .general_output_flag_pin, .mult_busy);
`default_nettype wire

// File: dmsd_mem_model.sv
// memory side model: captures stored words and counts sample moves
`timescale 1ns/1ps
`default_nettype none
module dmsd_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // strobes from the datapath
  input  wire logic [15:0] store_word,
  input  wire logic        store_valid,
  input  wire logic        data_move_strobe,
  // captured results
  output logic      [15:0] last_store,
  output int               move_cnt
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_store <= 16'h0000;
      move_cnt   <= 0;
    end else begin
      if (store_valid) last_store <= store_word;
      if (data_move_strobe) move_cnt <= move_cnt + 1;
    end
  end
endmodule : dmsd_mem_model
`default_nettype wire

// File: dmsd_datapath_bench.sv
// self-checking bench for the multiplier/scaler datapath
`timescale 1ns/1ps
`default_nettype none
module dmsd_datapath_bench import dmsd_pkg::*; ;
  logic        clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, aux_compare_true = 1'b0;
  logic        repeat_active = 1'b0;
  dmsd_op_t    op = DMSD_OP_NOP;
  dmsd_ctl_t   control_sel = DMSD_CTL_OVM;
  logic [15:0] data_word = 16'h0000, prog_word = 16'h0000, coef_start_addr = 16'h0100;
  logic [15:0] status_zero_in = 16'h0000, status_one_in = 16'h0000;
  logic [12:0] imm_word = 13'h0000;
  logic [4:0]  shift_const = 5'h00;
  logic [3:0]  bit_index = 4'h0;
  logic [1:0]  pm_field = 2'h0;
  wire  [31:0] accumulator, product_register;
  wire  [15:0] multiplier_operand_register, store_word, coef_addr, last_store;
  wire  [1:0]  product_shift_select;
  wire         overflow_event, overflow_saturate_mode, sign_extend_mode, test_flag;
  wire         general_output_flag_pin, store_valid, data_move_strobe, mult_busy;
  int          move_cnt, err_total = 0, cmp_count = 0;
  dmsd_datapath  dmsd_datapath_inst (.*);
  dmsd_mem_model dmsd_mem_model_inst (.*);
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // op_valid stays up so back-to-back issues need no extra edge
  task automatic issue(input dmsd_op_t o, input logic [15:0] d);
    op <= o;
    data_word <= d;
    op_valid <= 1'b1;
    @(posedge clk);
  endtask : issue
  task automatic idle(input int n);
    op_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic run(input dmsd_op_t o, input logic [15:0] d);
    issue(o, d);
    idle(1);
  endtask : run
  function automatic logic [31:0] ps(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return $signed(p) >>> 6;
      default: return p;
    endcase
  endfunction : ps
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk(product_shift_select, 2'h0);
    chk(sign_extend_mode, 1'h1);
    chk(general_output_flag_pin, 1'h1);
  endtask : s_reset
  task automatic s_pshift();
    logic [31:0] p = 32'hFFFF_D000;
    run(DMSD_OP_LOAD_OPND, 16'hF000);
    run(DMSD_OP_MPY, 16'h0003);
    chk(product_register, p);
    for (int m = 0; m < 4; m++) begin
      pm_field <= 2'(m);
      run(DMSD_OP_SET_PM, 16'h0000);
      run(DMSD_OP_LOAD_PROD, 16'hF000);
      chk(accumulator, ps(p, 2'(m)));
      run(DMSD_OP_STORE_HI, 16'h0000);
      idle(1);
      chk(last_store, ps(p, 2'(m)) >> 16);
      chk(product_register, p);
    end
    run(DMSD_OP_UNSIGNED_MULTIPLY_OP, 16'h0003);
    chk(product_register, 32'h0002_D000);
  endtask : s_pshift
  task automatic s_scale();
    logic [31:0] e [4] = '{32'hFFF8_0010, 32'h8001_0000, 32'h0008_0010, 32'h8001_0000};
    control_sel <= DMSD_CTL_SXM;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) run(DMSD_OP_CLR_BIT, 16'h0000);
      shift_const <= (i % 2) ? 5'h10 : 5'h04;
      run(DMSD_OP_LOAD_SHIFT, 16'h8001);
      chk(accumulator, e[i]);
    end
    run(DMSD_OP_SET_BIT, 16'h0000);
    shift_const <= 5'h00;
    run(DMSD_OP_LOAD_SHIFT, 16'h0000);
    run(DMSD_OP_ADD_NOSX, 16'h8001);
    chk(accumulator, 32'h0000_8001);
    run(DMSD_OP_LOAD_OPND, 16'h0003);
    run(DMSD_OP_ADD_DYN, 16'h0001);
    chk(accumulator, 32'h0000_8009);
  endtask : s_scale
  task automatic s_sat();
    logic [15:0] d [4] = '{16'h7FFF, 16'h7FFF, 16'h8000, 16'h8000};
    logic [31:0] e [4] = '{32'hFFFE_0000, 32'h7FFF_FFFF, 32'h0000_0000, 32'h8000_0000};
    shift_const <= 5'h10;
    control_sel <= DMSD_CTL_OVM;
    for (int i = 0; i < 4; i++) begin
      run(dmsd_op_t'(i % 2 ? DMSD_OP_SET_BIT : DMSD_OP_CLR_BIT), 16'h0000);
      run(DMSD_OP_LOAD_SHIFT, d[i]);
      run(DMSD_OP_ADD_SHIFT, d[i]);
      chk(accumulator, e[i]);
      chk(overflow_event, 1'h1);
    end
  endtask : s_sat
  task automatic s_imm();
    imm_word <= 13'h0001;
    run(DMSD_OP_LOAD_OPND, 16'h1234);
    issue(DMSD_OP_MPY_IMM, 16'h0000);
    issue(DMSD_OP_LOAD_OPND, 16'h5555);
    idle(2);
    chk(multiplier_operand_register, 16'h1234);
    chk(product_register, 32'h0000_1234);
    run(DMSD_OP_LOAD_PHI, 16'hABCD);
    chk(product_register, 32'hABCD_1234);
    imm_word <= 13'h0000;
    run(DMSD_OP_MPY_IMM, 16'h0000);
    idle(1);
    chk(product_register, 32'h0000_0000);
  endtask : s_imm
  task automatic s_mac();
    run(DMSD_OP_SQR_ADD, 16'hFFFD);
    chk(product_register, 32'h0000_0009);
    prog_word <= 16'h0002;
    for (int i = 0; i < 3; i++) begin
      repeat_active <= (i != 0);
      issue(DMSD_OP_MAC_MOVE, 16'h0001);
    end
    idle(2);
    chk(coef_addr, coef_start_addr + 16'h0002);
    chk(product_register, 32'h0000_0002);
    chk(move_cnt, 32'h0000_0003);
  endtask : s_mac
  task automatic s_tc();
    run(DMSD_OP_BIT_TEST, 16'h8000);
    chk(test_flag, 1'h1);
    run(DMSD_OP_BIT_TEST, 16'h7FFF);
    chk(test_flag, 1'h0);
    aux_compare_true <= 1'b1;
    run(DMSD_OP_AUX_CMP, 16'h0000);
    chk(test_flag, 1'h1);
    run(DMSD_OP_BIT_DYN, 16'hBFFF);
    chk(test_flag, 1'h0);
    control_sel <= DMSD_CTL_XF;
    run(DMSD_OP_CLR_BIT, 16'h0000);
    chk(general_output_flag_pin, 1'h0);
    run(DMSD_OP_SET_BIT, 16'h0000);
    chk(general_output_flag_pin, 1'h1);
  endtask : s_tc
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    s_reset();
    s_pshift();
    s_scale();
    s_sat();
    s_imm();
    s_mac();
    s_tc();
    tally_and_finish();
  end
  // whole run is about 130 cycles; the 2000-cycle limit allows ample margin
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule : dmsd_datapath_bench
`default_nettype wire
